// file: rtl/afp_map.svh
`ifndef AFP_MAP_SVH
`define AFP_MAP_SVH

// Half-bridge indices.
`define AFP_HB_A 0
`define AFP_HB_B 1
`define AFP_HB_C 2
`define AFP_HB_D 3
`define AFP_NUM_HB 4

// Output configuration codes.
`define AFP_MODE_BTL 2'h0
`define AFP_MODE_PARALLEL_BRIDGE_MODE 2'h1
`define AFP_MODE_SE 2'h2

// Warning thresholds in degrees C, for reference by the comparator owner.
`define AFP_WARN_LOW_DEGC 100
`define AFP_WARN_HIGH_DEGC 125

// Least spacing from shutdown flag falling to reset rising, in us.
`define AFP_RELEASE_WAIT_US 4000
`define AFP_CLK_MHZ 200
`define AFP_RELEASE_WAIT_CYC (`AFP_RELEASE_WAIT_US * `AFP_CLK_MHZ)

`endif

// file: rtl/afp_pkg.sv
`default_nettype none
package afp_pkg;
  typedef enum logic [1:0] {
    AFP_BTL  = 2'h0,
    AFP_PARALLEL_BRIDGE_MODE = 2'h1,
    AFP_SE   = 2'h2
  } afp_mode_t;

  typedef enum logic [2:0] {
    AFP_ST_HOLD = 3'h1,
    AFP_ST_RUN  = 3'h2,
    AFP_ST_TRIP = 3'h4
  } afp_state_t;
endpackage
`default_nettype wire

// file: rtl/afp_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface afp_sync_if;
  logic [8:0] raw;
  logic [8:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface
`default_nettype wire

// file: rtl/afp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module afp_sync (
  // Clock and control
  input  wire logic  core_clk_in,
  input  wire logic  rst_in,
  input  wire logic  ce_in,
  // Bits to synchronise
  afp_sync_if.dst    bus
);
  logic [8:0] meta_q;
  logic [8:0] meta_d;
  logic [8:0] sync_q;
  logic [8:0] sync_d;

  always_comb
  begin
    meta_d = ce_in ? bus.raw : meta_q;
    sync_d = ce_in ? meta_q : sync_q;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 9'h000;
      sync_q <= 9'h000;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign bus.synced = sync_q;
endmodule
`default_nettype wire

// file: rtl/afp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "afp_map.svh"
module afp_monitor (
  // Clock, enable, synchronous reset
  input  wire logic        core_clk_in,
  input  wire logic        ce_in,
  input  wire logic        rst_in,
  // Device reset pin, active low
  input  wire logic        reset_n_in,
  // Output configuration strap
  input  wire logic [1:0]  mode_in,
  // Comparator and monitor levels, active high
  input  wire logic        temp_above_low_in,
  input  wire logic        temp_above_high_in,
  input  wire logic        overtemp_error_in,
  input  wire logic [3:0]  overload_protect_in,
  input  wire logic        common_supply_ok_in,
  input  wire logic [3:0]  gate_drive_supply_ok_in,
  input  wire logic [3:0]  bootstrap_supply_ok_in,
  // Open-drain flags: output level and enable (enable low drives)
  output logic             fault_shutdown_n_out,
  output logic             fault_shutdown_n_oe_n_out,
  output logic             temp_warn_n_out,
  output logic             temp_warn_n_oe_n_out,
  output logic             temp_warn_low_n_out,
  output logic             temp_warn_low_n_oe_n_out,
  output logic             temp_warn_high_n_out,
  output logic             temp_warn_high_n_oe_n_out,
  // Power stage control per half-bridge
  output logic [3:0]       bridge_enable_out,
  output logic [3:0]       bridge_pulldown_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  afp_sync_if sif ();

  assign sif.raw = {reset_n_in, temp_above_low_in, temp_above_high_in, overtemp_error_in,
                    common_supply_ok_in, (&gate_drive_supply_ok_in), (|overload_protect_in),
                    (|overload_protect_in[1:0]), (|overload_protect_in[3:2])};

  afp_sync u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .bus         (sif.dst)
  );

  logic       rst_pin_n;
  logic       t_low;
  logic       t_high;
  logic       overtemp_error;
  logic       vdd_ok;
  logic       gvdd_ok;
  logic       olp_any;
  logic       olp_ab;
  logic       olp_cd;

  assign {rst_pin_n, t_low, t_high, overtemp_error, vdd_ok, gvdd_ok, olp_any, olp_ab, olp_cd} = sif.synced;

  // Bootstrap monitors are per half-bridge and pass their own pair of flops.
  logic [3:0] bst_meta_q;
  logic [3:0] bst_meta_d;
  logic [3:0] bst_ok_q;
  logic [3:0] bst_ok_d;

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches and state.

  afp_pkg::afp_state_t state_q;
  afp_pkg::afp_state_t state_d;
  logic       ote_lat_q;
  logic       ote_lat_d;
  logic       olp_ab_q;
  logic       olp_ab_d;
  logic       olp_cd_q;
  logic       olp_cd_d;
  logic       rst_pin_q;
  logic       rst_pin_d;
  logic       supplies_ok;
  logic       rise;
  logic       global_fault;
  logic       grp_ab_fault;
  logic       grp_cd_fault;
  logic       shut_any;
  logic [3:0] kill;

  assign supplies_ok = vdd_ok & gvdd_ok;
  assign rise        = rst_pin_n & ~rst_pin_q;

  always_comb
  begin
    bst_meta_d = ce_in ? bootstrap_supply_ok_in : bst_meta_q;
    bst_ok_d   = ce_in ? bst_meta_q : bst_ok_q;
    rst_pin_d  = ce_in ? rst_pin_n : rst_pin_q;
    ote_lat_d  = ote_lat_q;
    olp_ab_d   = olp_ab_q;
    olp_cd_d   = olp_cd_q;
    state_d    = state_q;
    if (ce_in)
    begin
      // Reset low clears the temperature latch; a new error sets it only while reset is high.
      if (!rst_pin_n)
        ote_lat_d = 1'b0;
      if (overtemp_error && rst_pin_n)
        ote_lat_d = 1'b1;
      // Overload is cleared only by a rising edge of the reset pin.
      if (rise)
      begin
        olp_ab_d = 1'b0;
        olp_cd_d = 1'b0;
      end
      if (olp_ab && rst_pin_n)
        olp_ab_d = 1'b1;
      if (olp_cd && rst_pin_n)
        olp_cd_d = 1'b1;
      unique case (state_q)
        afp_pkg::AFP_ST_HOLD:
          if (rst_pin_n && supplies_ok)
            state_d = afp_pkg::AFP_ST_RUN;
        afp_pkg::AFP_ST_RUN:
          if (!rst_pin_n)
            state_d = afp_pkg::AFP_ST_HOLD;
          else if (shut_any)
            state_d = afp_pkg::AFP_ST_TRIP;
        afp_pkg::AFP_ST_TRIP:
          if (!rst_pin_n)
            state_d = afp_pkg::AFP_ST_HOLD;
          else if (!shut_any)
            state_d = afp_pkg::AFP_ST_RUN;
        default:
          state_d = afp_pkg::AFP_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      bst_meta_q <= 4'h0;
      bst_ok_q   <= 4'h0;
      rst_pin_q  <= 1'b0;
      ote_lat_q  <= 1'b0;
      olp_ab_q   <= 1'b0;
      olp_cd_q   <= 1'b0;
      state_q    <= afp_pkg::AFP_ST_HOLD;
    end
    else
    begin
      bst_meta_q <= bst_meta_d;
      bst_ok_q   <= bst_ok_d;
      rst_pin_q  <= rst_pin_d;
      ote_lat_q  <= ote_lat_d;
      olp_ab_q   <= olp_ab_d;
      olp_cd_q   <= olp_cd_d;
      state_q    <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown decision, grouped by output configuration.

  // Faults are looked at live as well as latched so Hi-Z follows at once.
  assign global_fault = overtemp_error | ote_lat_q | ~supplies_ok;
  // The latch clears on the reset rising edge itself; masking it here keeps
  // the stale copy from pulsing the shutdown flag for one cycle.
  assign grp_ab_fault = olp_ab | (olp_ab_q & ~rise);
  assign grp_cd_fault = olp_cd | (olp_cd_q & ~rise);
  assign shut_any     = global_fault | grp_ab_fault | grp_cd_fault;

  always_comb
  begin
    kill = {4{global_fault}};
    if (mode_in == `AFP_MODE_PARALLEL_BRIDGE_MODE)
      kill = kill | {4{olp_any | grp_ab_fault | grp_cd_fault}};
    else
      kill = kill | {{2{grp_cd_fault}}, {2{grp_ab_fault}}};
    kill = kill | ~bst_ok_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic [3:0] en_q;
  logic [3:0] en_d;
  logic [3:0] pd_q;
  logic [3:0] pd_d;
  logic       sd_q;
  logic       sd_d;
  logic       wl_q;
  logic       wl_d;
  logic       wh_q;
  logic       wh_d;

  always_comb
  begin
    en_d = en_q;
    pd_d = pd_q;
    sd_d = sd_q;
    wl_d = wl_q;
    wh_d = wh_q;
    if (ce_in)
    begin
      // Reset low or bad common or gate-drive supplies keep every bridge off.
      en_d = (rst_pin_n && supplies_ok && (state_q != afp_pkg::AFP_ST_HOLD)) ? ~kill : 4'h0;
      // Single-ended outputs get no pulldown, they stay Hi-Z under reset.
      pd_d = (!rst_pin_n && (mode_in != `AFP_MODE_SE)) ? 4'hf : 4'h0;
      sd_d = rst_pin_n & shut_any;
      wl_d = t_low;
      wh_d = t_high;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      en_q <= 4'h0;
      pd_q <= 4'h0;
      sd_q <= 1'b0;
      wl_q <= 1'b0;
      wh_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      pd_q <= pd_d;
      sd_q <= sd_d;
      wl_q <= wl_d;
      wh_q <= wh_d;
    end
  end

  // Open-drain: level is always low, enable low only while pulling.
  assign fault_shutdown_n_out      = 1'b0;
  assign fault_shutdown_n_oe_n_out = ~sd_q;
  assign temp_warn_n_out           = 1'b0;
  assign temp_warn_n_oe_n_out      = ~wh_q;
  assign temp_warn_low_n_out       = 1'b0;
  assign temp_warn_low_n_oe_n_out  = ~wl_q;
  assign temp_warn_high_n_out      = 1'b0;
  assign temp_warn_high_n_oe_n_out = ~wh_q;
  assign bridge_enable_out         = en_q;
  assign bridge_pulldown_out       = pd_q;

endmodule
`default_nettype wire

// file: tb/afp_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module afp_monitor_assertions (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire logic       ce_in,
  input wire logic       reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic       temp_above_low_in,
  input wire logic       temp_above_high_in,
  input wire logic       overtemp_error_in,
  input wire logic [3:0] overload_protect_in,
  input wire logic       common_supply_ok_in,
  input wire logic       fault_shutdown_n_out,
  input wire logic       fault_shutdown_n_oe_n_out,
  input wire logic       temp_warn_n_out,
  input wire logic       temp_warn_low_n_out,
  input wire logic       temp_warn_high_n_out,
  input wire logic       temp_warn_n_oe_n_out,
  input wire logic       temp_warn_low_n_oe_n_out,
  input wire logic       temp_warn_high_n_oe_n_out,
  input wire logic [3:0] bridge_enable_out,
  input wire logic [3:0] bridge_pulldown_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Holds off every check except a_flag_pull_only until the synchronisers have flushed values seen during reset
  // or while the clock enable froze the pipeline.
  logic [2:0] up_q;
  logic [2:0] up_d;
  always_comb up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
  always_ff @(posedge core_clk_in) up_q <= (rst_in || !ce_in) ? 3'h0 : up_d;
  sequence s_ot_trip;
    up_q == 3'h7 && reset_n_in && $rose(overtemp_error_in);
  endsequence
  sequence s_rst_low;
    (up_q == 3'h7 && !reset_n_in) [*5];
  endsequence
  a_flag_pull_only: assert property (
    fault_shutdown_n_out == 1'b0 && temp_warn_n_out == 1'b0 &&
    temp_warn_low_n_out == 1'b0 && temp_warn_high_n_out == 1'b0) else $error("flag drives high");
  a_warn_high_follow: assert property (
    up_q == 3'h7 && $past(temp_above_high_in, 3) == $past(temp_above_high_in, 4) |->
    temp_warn_high_n_oe_n_out == !$past(temp_above_high_in, 3) && temp_warn_n_oe_n_out == temp_warn_high_n_oe_n_out)
    else $error("high warning wrong");
  a_warn_low_follow: assert property (
    up_q == 3'h7 && $past(temp_above_low_in, 3) == $past(temp_above_low_in, 4) |->
    temp_warn_low_n_oe_n_out == !$past(temp_above_low_in, 3)) else $error("low warning wrong");
  a_ot_trip_latch: assert property (
    s_ot_trip ##1 reset_n_in [*8] |-> !fault_shutdown_n_oe_n_out && bridge_enable_out == 4'h0)
    else $error("overtemp not latched");
  a_reset_release: assert property (
    s_rst_low |-> fault_shutdown_n_oe_n_out && bridge_enable_out == 4'h0) else $error("reset not released");
  a_reset_pulldown: assert property (
    s_rst_low |-> bridge_pulldown_out == ((mode_in == afp_pkg::AFP_SE) ? 4'h0 : 4'hf)) else $error("pulldown wrong");
  a_uv_global_off: assert property (
    (up_q == 3'h7 && reset_n_in && !common_supply_ok_in) [*5] |->
    bridge_enable_out == 4'h0 && !fault_shutdown_n_oe_n_out) else $error("undervoltage not off");
  a_parallel_bridge_mode_all_off: assert property (
    (up_q == 3'h7 && reset_n_in && mode_in == afp_pkg::AFP_PARALLEL_BRIDGE_MODE && overload_protect_in != 4'h0) [*5] |->
    bridge_enable_out == 4'h0) else $error("parallel mode not all off");
endmodule
`default_nettype wire

// file: tb/afp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module afp_ctrl_model #(
  parameter int WAIT_CYC = 8
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_req_in,
  input  wire logic [3:0] oe_n_in,
  input  wire logic [3:0] drv_in,
  output logic [3:0]      level_out,
  output var logic        reset_n_out = 1'b0
);
  // Released flags read high through the pull-up.
  assign level_out = oe_n_in | drv_in;
  logic [15:0] since_q = 16'hffff;
  logic        sd_q    = 1'b1;
  // Reset is only raised once enough cycles have passed since the shutdown flag last fell.
  always @(posedge core_clk_in)
  begin
    sd_q <= level_out[0];
    since_q <= (sd_q === 1'b1 && level_out[0] === 1'b0) ? 16'h0 : (since_q == 16'hffff) ? since_q : since_q + 16'h1;
    reset_n_out <= rst_req_in ? 1'b0 : (reset_n_out || since_q >= 16'(WAIT_CYC));
  end
endmodule
`default_nettype wire

// file: tb/afp_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module afp_monitor_tb_top;
  logic       core_clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       ce_in = 1'b1;
  logic       rst_req = 1'b1;
  logic [1:0] mode_in = 2'h0;
  logic       temp_above_low_in = 1'b0;
  logic       temp_above_high_in = 1'b0;
  logic       overtemp_error_in = 1'b0;
  logic [3:0] overload_protect_in = 4'h0;
  logic       common_supply_ok_in = 1'b1;
  logic [3:0] gate_drive_supply_ok_in = 4'hf;
  logic [3:0] bootstrap_supply_ok_in = 4'hf;
  wire        reset_n_in, fault_shutdown_n_out, fault_shutdown_n_oe_n_out, temp_warn_n_out, temp_warn_n_oe_n_out;
  wire        temp_warn_low_n_out, temp_warn_low_n_oe_n_out, temp_warn_high_n_out, temp_warn_high_n_oe_n_out;
  wire [3:0]  bridge_enable_out, bridge_pulldown_out, lvl;
  int         n_fail = 0, n_checks = 0, seed = 1540, cyc = 0;
  logic [11:0] q[$];
  logic [11:0] exp_v;
  event       ev;
  always #2.5 core_clk_in = ~core_clk_in;
  afp_monitor u_dut (.*);
  afp_ctrl_model #(.WAIT_CYC(8)) u_ctrl (
    .core_clk_in(core_clk_in), .rst_req_in(rst_req), .level_out(lvl), .reset_n_out(reset_n_in),
    .oe_n_in({temp_warn_high_n_oe_n_out, temp_warn_low_n_oe_n_out, temp_warn_n_oe_n_out, fault_shutdown_n_oe_n_out}),
    .drv_in({temp_warn_high_n_out, temp_warn_low_n_out, temp_warn_n_out, fault_shutdown_n_out}));
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Flags are {shutdown, low warning, high warning}; the 3-edge latency is well covered by 6.
  task automatic chk(input logic [2:0] f, input logic [3:0] en, input logic [3:0] pd);
    repeat (6) @(posedge core_clk_in);
    q.push_back({f[0], f[1], f[0], f[2], en, pd});
    -> ev;
  endtask
  task automatic recover(input logic [3:0] pd);
    rst_req <= 1'b1;
    chk(3'h7, 4'h0, pd);
    rst_req <= 1'b0;
    chk(3'h7, 4'hf, 4'h0);
  endtask
  always @(ev)
  begin
    #1;
    exp_v = q.pop_front();
    `CMP({lvl, bridge_enable_out, bridge_pulldown_out}, exp_v)
  end
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int i;
    logic [3:0] pdx, grp;
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int m = 0; m < 3; m++)
    begin
      i = $random(seed) & 3;
      pdx = (m == 2) ? 4'h0 : 4'hf;
      grp = (m == 1) ? 4'h0 : (i < 2) ? 4'hc : 4'h3;
      mode_in <= 2'(m);
      recover(pdx);
      temp_above_low_in <= 1'b1;
      chk(3'h5, 4'hf, 4'h0);
      temp_above_high_in <= 1'b1;
      chk(3'h4, 4'hf, 4'h0);
      temp_above_low_in <= 1'b0;
      temp_above_high_in <= 1'b0;
      chk(3'h7, 4'hf, 4'h0);
      ce_in <= 1'b0;
      temp_above_high_in <= 1'b1;
      chk(3'h7, 4'hf, 4'h0);
      ce_in <= 1'b1;
      chk(3'h6, 4'hf, 4'h0);
      temp_above_high_in <= 1'b0;
      overload_protect_in <= 4'h1 << i;
      chk(3'h3, grp, 4'h0);
      overload_protect_in <= 4'h0;
      chk(3'h3, grp, 4'h0);
      recover(pdx);
      bootstrap_supply_ok_in <= ~(4'h1 << i);
      chk(3'h7, ~(4'h1 << i), 4'h0);
      bootstrap_supply_ok_in <= 4'hf;
      common_supply_ok_in <= 1'b0;
      chk(3'h3, 4'h0, 4'h0);
      common_supply_ok_in <= 1'b1;
      gate_drive_supply_ok_in <= ~(4'h1 << i);
      chk(3'h3, 4'h0, 4'h0);
      gate_drive_supply_ok_in <= 4'hf;
      chk(3'h7, 4'hf, 4'h0);
      overtemp_error_in <= 1'b1;
      chk(3'h3, 4'h0, 4'h0);
      overtemp_error_in <= 1'b0;
      chk(3'h3, 4'h0, 4'h0);
      recover(pdx);
      $display("mode %0d done", m);
    end
    give_verdict();
  end
endmodule
bind afp_monitor afp_monitor_assertions u_chk (.*);
`default_nettype wire
